// ==== src/afel_consts.vh ====
// Constants for the alarm, fault and error log supervisor.
// Assumes a 20 MHz mclk; included by bare name from src/.
`ifndef AFEL_CONSTS_VH
`define AFEL_CONSTS_VH

// Timing
`define AFEL_CLK_HZ        20000000
`define AFEL_MINUTE_S      60
`define AFEL_MINUTES_HOUR  6'h3b
`define AFEL_HOURS_DAY     5'h17
`define AFEL_DAY_LAST      8'hf7

// Log geometry
`define AFEL_LOG_DEPTH     4'ha
`define AFEL_LOG_LAST      4'h9

// Register byte offsets
`define AFEL_REG_CTRL      6'h00
`define AFEL_REG_LINEV     6'h04
`define AFEL_REG_AMODE     6'h08
`define AFEL_REG_STATUS    6'h0c
`define AFEL_REG_LOGSEL    6'h10
`define AFEL_REG_LOGDATA   6'h14
`define AFEL_REG_LOGCNT    6'h18
`define AFEL_REG_CLOCK     6'h1c

// CTRL bit positions
`define AFEL_CTRL_IDEN     0
`define AFEL_CTRL_TUNEEN   1
`define AFEL_CTRL_ETMRST   2
`define AFEL_CTRL_FRESET   3

// Reset values
`define AFEL_LINEV_RST     10'h1cc
`define AFEL_AMODE_RST     4'h0

// Thresholds
`define AFEL_LINE_SPLIT    10'h19f
`define AFEL_BUS_HI_TRIP   10'h2e5
`define AFEL_BUS_LO_TRIP   10'h29d
`define AFEL_LOOP_MIN_UA   16'h07d0
`define AFEL_AMODE_LOOP_LO 4'h8
`define AFEL_AMODE_LOOP_HI 4'hb

// Display codes for alarms; faults bring their own nonzero code
`define AFEL_CODE_BLANK    8'h00
`define AFEL_CODE_ALOSS    8'h01
`define AFEL_CODE_HIBUS    8'h02
`define AFEL_CODE_IDACT    8'h03
`define AFEL_CODE_IDEN     8'h04
`define AFEL_CODE_LOLINE   8'h05
`define AFEL_CODE_STACT    8'h06
`define AFEL_CODE_STEN     8'h07

`endif

// ==== src/afel_log_ram.v ====
// Power-safe error log with day and time stamp clock.
// Assumes its contents sit in a backed-up domain cleared only by nvClear.
`timescale 1ns/1ps
`default_nettype none
`include "afel_consts.vh"

module afel_log_ram #(
  parameter MINUTE_CYCLES = `AFEL_MINUTE_S * `AFEL_CLK_HZ
) (
  input  wire        mclk,
  input  wire        nvClear,
  input  wire        etmReset,
  input  wire        wrEn,
  input  wire [7:0]  wrCode,
  input  wire [3:0]  rdSel,
  output wire [30:0] rdEntry,
  output reg  [3:0]  logCount,
  output wire [18:0] clockNow
);

  reg [7:0]  logMem [0:9];
  reg [7:0]  dayMem [0:9];
  reg [10:0] hmMem  [0:9];
  reg [3:0]  head;
  reg [30:0] minuteDiv;
  reg [7:0]  day;
  reg [4:0]  hour;
  reg [5:0]  minute;
  wire [3:0] phys;
  wire [3:0] seq;

  // Slot k back from the newest, wrapping over ten slots
  function [3:0] backIdx;
    input [3:0] hd;
    input [3:0] k;
    reg   [4:0] t;
    begin
      t = {1'b0, hd} + {1'b0, `AFEL_LOG_DEPTH} - 5'h01 - {1'b0, k};
      if (t >= {1'b0, `AFEL_LOG_DEPTH})
        t = t - {1'b0, `AFEL_LOG_DEPTH};
      backIdx = t[3:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Relative day and 24 hour clock, cleared by elapsed time reset
  always @(posedge mclk) begin
    if (nvClear || etmReset) begin // R12
      minuteDiv <= 31'h0;
      day       <= 8'h00;
      hour      <= 5'h00;
      minute    <= 6'h00;
    end else if (minuteDiv == MINUTE_CYCLES - 1) begin
      minuteDiv <= 31'h0;
      if (minute == `AFEL_MINUTES_HOUR) begin
        minute <= 6'h00;
        if (hour == `AFEL_HOURS_DAY) begin // R11
          hour <= 5'h00;
          day  <= (day == `AFEL_DAY_LAST) ? 8'h00 : day + 8'h01; // R10
        end else begin
          hour <= hour + 5'h01;
        end
      end else begin
        minute <= minute + 6'h01;
      end
    end else begin
      minuteDiv <= minuteDiv + 31'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Circular store; oldest slot is overwritten once full
  always @(posedge mclk) begin
    if (nvClear) begin // R13
      head     <= 4'h0;
      logCount <= 4'h0;
    end else if (wrEn) begin
      head <= (head == `AFEL_LOG_LAST) ? 4'h0 : head + 4'h1; // R7
      if (logCount != `AFEL_LOG_DEPTH)
        logCount <= logCount + 4'h1;
    end
  end

  // Entry data with the stamp of the detection cycle
  always @(posedge mclk) begin
    if (wrEn) begin // R24
      logMem[head] <= wrCode;
      dayMem[head] <= day;
      hmMem[head]  <= {hour, minute};
    end
  end

  // Newest first; its number is the highest one
  assign phys    = backIdx(head, rdSel); // R8
  assign seq     = logCount - 4'h1 - rdSel; // R9
  assign rdEntry = (rdSel < logCount) ?
                   {seq, logMem[phys], dayMem[phys], hmMem[phys]} : 31'h0;
  assign clockNow = {day, hour, minute};

endmodule
`default_nettype wire

// ==== src/afel_supervisor.v ====
// Alarm and fault supervisor with error log for a motor drive.
// Assumes condition inputs synchronous to mclk; Wishbone classic slave.
//
// Overview of operation
// R1: Alarm present flashes its code; drive keeps running.
// R2: Alarm code disappears by itself once its cause is gone.
// R3: Fault coasts the motor, drops the running indicator, flashes code.
// R4: First fault stays displayed; later faults never replace it.
// R5: Fault latch clears only on stop/reset key or fault reset input; the code also clears it on the CTRL fault reset bit.
// R6: Every fault is logged; no display sign that the log holds entries.
// R7: Log keeps ten newest faults; new fault pushes out the oldest.
// R8: Log read-out presents newest fault first.
// R9: Entries numbered sequentially; newest highest, never above nine.
// R10: Each entry carries a day stamp wrapping at 248 days.
// R11: Each entry carries 24 hour time, hours then two minute digits.
// R12: Elapsed time meter reset clears day and time clock.
// R13: Log and clock survive power loss.
// R14: Analog loss alarm in modes 8 to 11 below 2 mA.
// R15: High bus alarm above 741 V if line above 415, else 669 V.
// R16: Low line alarm while AC line is low.
// R17: Identification enabled alarm before start, active alarm after start.
// R18: Stop/reset key aborts a running identification.
// R19: Identification enable off cancels it and clears its alarm.
// R20: Self-tuning enabled alarm before start, active alarm until done.
// R21: Self-tuning enable off cancels it and clears its alarm.
// R22: Stop/reset key cancels running self-tuning.
// R23: Faults after the first are still logged.
// R24: Fault logged with stamp in its detection cycle, before any reset.
`timescale 1ns/1ps
`default_nettype none
`include "afel_consts.vh"

module afel_supervisor #(
  parameter MINUTE_CYCLES = `AFEL_MINUTE_S * `AFEL_CLK_HZ
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        nvClear,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Condition detectors
  input  wire [9:0]  dcBusVolts,
  input  wire [15:0] loopMicroAmps,
  input  wire        lineLow,
  input  wire        faultValid,
  input  wire [7:0]  faultCode,
  // Operator and control source
  input  wire        startCmd,
  input  wire        stopResetKey,
  input  wire        faultResetIn,
  input  wire        idDone,
  input  wire        tuneDone,
  // Drive and display
  output reg         runningIndicator,
  output reg         coastStop,
  output reg  [7:0]  displayCode,
  output reg         displayFlash,
  output wire        idRunning,
  output wire        tuneRunning
);

  localparam [2:0] P_IDLE    = 3'h1;
  localparam [2:0] P_ENABLED = 3'h2;
  localparam [2:0] P_ACTIVE  = 3'h4;

  reg  [1:0]  procEn;
  reg  [9:0]  lineNominal;
  reg  [3:0]  analogMode;
  reg  [3:0]  logSel;
  reg         etmPulse;
  reg         faultLatched;
  reg  [7:0]  firstFault;
  reg         driveStarted;
  reg  [7:0]  next_display;
  wire [1:0]  procDone;
  wire [1:0]  procClear;
  wire [1:0]  procEnabled;
  wire [1:0]  procActive;
  wire        wbReq;
  wire        wbWr;
  wire        resetReq;
  wire        alarmAnalog;
  wire        alarmHiBus;
  wire [30:0] logEntry;
  wire [3:0]  logCount;
  wire [18:0] clockNow;

  // Trip threshold chosen by the nominal line setting
  function [9:0] busTrip;
    input [9:0] nominal;
    begin
      if (nominal > `AFEL_LINE_SPLIT)
        busTrip = `AFEL_BUS_HI_TRIP;
      else
        busTrip = `AFEL_BUS_LO_TRIP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one request per cycle, ack in the next
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr  = wbReq && wb_we_i && wb_sel_i[0];

  // Ack rises one cycle after the request and drops after one cycle
  always @(posedge mclk) begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbReq;
  end

  // Read data latched with the ack; unmapped offsets read zero
  always @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else if (wbReq) begin
      if (wb_adr_i == `AFEL_REG_CTRL)
        wb_dat_o <= {30'h0, procEn};
      else if (wb_adr_i == `AFEL_REG_LINEV)
        wb_dat_o <= {22'h0, lineNominal};
      else if (wb_adr_i == `AFEL_REG_AMODE)
        wb_dat_o <= {28'h0, analogMode};
      else if (wb_adr_i == `AFEL_REG_STATUS)
        wb_dat_o <= {8'h0, displayCode, procActive, procEnabled,
                     lineLow, alarmHiBus, alarmAnalog, driveStarted,
                     firstFault};
      else if (wb_adr_i == `AFEL_REG_LOGSEL)
        wb_dat_o <= {28'h0, logSel};
      else if (wb_adr_i == `AFEL_REG_LOGDATA)
        wb_dat_o <= {1'b0, logEntry};
      else if (wb_adr_i == `AFEL_REG_LOGCNT)
        wb_dat_o <= {28'h0, logCount};
      else if (wb_adr_i == `AFEL_REG_CLOCK)
        wb_dat_o <= {13'h0, clockNow};
      else
        wb_dat_o <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings written by software
  always @(posedge mclk) begin
    if (rst) begin
      lineNominal <= `AFEL_LINEV_RST;
      analogMode  <= `AFEL_AMODE_RST;
      logSel      <= 4'h0;
    end else if (wbWr) begin
      if (wb_adr_i == `AFEL_REG_LINEV) begin
        lineNominal[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          lineNominal[9:8] <= wb_dat_i[9:8];
      end else if (wb_adr_i == `AFEL_REG_AMODE) begin
        analogMode <= wb_dat_i[3:0];
      end else if (wb_adr_i == `AFEL_REG_LOGSEL) begin
        logSel <= (wb_dat_i[3:0] > `AFEL_LOG_LAST) ?
                  `AFEL_LOG_LAST : wb_dat_i[3:0];
      end
    end
  end

  // Procedure enables; cleared when a procedure ends or is aborted
  always @(posedge mclk) begin
    if (rst) begin
      procEn <= 2'h0;
    end else begin
      if (wbWr && wb_adr_i == `AFEL_REG_CTRL)
        procEn <= {wb_dat_i[`AFEL_CTRL_TUNEEN], wb_dat_i[`AFEL_CTRL_IDEN]};
      else
        procEn <= procEn & ~procClear;
    end
  end

  // Elapsed time meter reset is a one-cycle strobe
  always @(posedge mclk) begin
    if (rst)
      etmPulse <= 1'b0;
    else
      etmPulse <= wbWr && (wb_adr_i == `AFEL_REG_CTRL) &&
                  wb_dat_i[`AFEL_CTRL_ETMRST];
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm detection, combinational so alarms follow their cause
  assign alarmAnalog = (analogMode >= `AFEL_AMODE_LOOP_LO) &&
                       (analogMode <= `AFEL_AMODE_LOOP_HI) &&
                       (loopMicroAmps < `AFEL_LOOP_MIN_UA); // R14
  assign alarmHiBus  = dcBusVolts > busTrip(lineNominal); // R15

  ////////////////////////////////////////////////////////////////////////
  // Fault latch: first fault held, reset from key, input or software
  assign resetReq = stopResetKey || faultResetIn ||
                    (wbWr && (wb_adr_i == `AFEL_REG_CTRL) &&
                     wb_dat_i[`AFEL_CTRL_FRESET]);

  // A fault arriving with the reset wins over the clear
  always @(posedge mclk) begin
    if (rst) begin
      faultLatched <= 1'b0;
      firstFault   <= `AFEL_CODE_BLANK;
    end else if (faultValid && !faultLatched) begin
      faultLatched <= 1'b1;
      firstFault   <= faultCode;
    end else if (faultValid) begin
      faultLatched <= 1'b1; // R4
    end else if (resetReq) begin
      faultLatched <= 1'b0; // R5
      firstFault   <= `AFEL_CODE_BLANK;
    end
  end

  // Run state: faults coast the motor, alarms leave it running
  always @(posedge mclk) begin
    if (rst) begin
      driveStarted     <= 1'b0;
      runningIndicator <= 1'b0;
      coastStop        <= 1'b0;
    end else begin
      coastStop <= faultLatched || faultValid; // R3
      if (faultValid || faultLatched || stopResetKey) begin
        driveStarted     <= 1'b0; // R3
        runningIndicator <= 1'b0;
      end else if (startCmd) begin
        driveStarted     <= 1'b1; // R1
        runningIndicator <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identification (0) and self-tuning (1) sequencers
  assign procDone = {tuneDone, idDone};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gProc
      reg [2:0] pState;
      reg       next_clear;

      // Enabled waits for start, active runs until done or abort
      always @(posedge mclk) begin
        if (rst) begin
          pState <= P_IDLE;
        end else begin
          case (pState)
            P_IDLE: begin
              if (procEn[gi])
                pState <= P_ENABLED;
            end
            P_ENABLED: begin
              if (!procEn[gi])
                pState <= P_IDLE; // R19 R21
              else if (driveStarted)
                pState <= P_ACTIVE; // R17 R20
            end
            P_ACTIVE: begin
              if (!procEn[gi] || stopResetKey || procDone[gi] ||
                  faultLatched)
                pState <= P_IDLE; // R18 R22
            end
            default: begin
              pState <= P_IDLE;
            end
          endcase
        end
      end

      // Ending or aborting a run drops its enable
      always @* begin
        next_clear = (pState == P_ACTIVE) &&
                     (stopResetKey || procDone[gi] || faultLatched);
      end

      assign procClear[gi]   = next_clear;
      assign procEnabled[gi] = (pState == P_ENABLED);
      assign procActive[gi]  = (pState == P_ACTIVE);
    end
  endgenerate

  assign idRunning   = procActive[0];
  assign tuneRunning = procActive[1];

  ////////////////////////////////////////////////////////////////////////
  // Display select: latched fault first, then alarms by fixed order
  always @* begin
    if (faultLatched)
      next_display = firstFault; // R4
    else if (alarmHiBus)
      next_display = `AFEL_CODE_HIBUS;
    else if (alarmAnalog)
      next_display = `AFEL_CODE_ALOSS;
    else if (lineLow)
      next_display = `AFEL_CODE_LOLINE; // R16
    else if (procActive[0])
      next_display = `AFEL_CODE_IDACT;
    else if (procEnabled[0])
      next_display = `AFEL_CODE_IDEN;
    else if (procActive[1])
      next_display = `AFEL_CODE_STACT;
    else if (procEnabled[1])
      next_display = `AFEL_CODE_STEN;
    else
      next_display = `AFEL_CODE_BLANK; // R2 R6
  end

  // Display registers; any shown code flashes
  always @(posedge mclk) begin
    if (rst) begin
      displayCode  <= `AFEL_CODE_BLANK;
      displayFlash <= 1'b0;
    end else begin
      displayCode  <= next_display; // R1
      displayFlash <= (next_display != `AFEL_CODE_BLANK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error log: every fault, first or later, is stored
  afel_log_ram #(
    .MINUTE_CYCLES (MINUTE_CYCLES)
  ) uLog (
    .mclk     (mclk),
    .nvClear  (nvClear),
    .etmReset (etmPulse),
    .wrEn     (faultValid), // R6 R23 R24
    .wrCode   (faultCode),
    .rdSel    (logSel),
    .rdEntry  (logEntry),
    .logCount (logCount),
    .clockNow (clockNow)
  );

endmodule
`default_nettype wire

// ==== tb/afel_sup_assertions.sv ====
// Concurrent checks on the supervisor top ports.
// Assumes binding into afel_supervisor; one mclk domain, sync rst.
`timescale 1ns/1ps
`default_nettype none
module afel_sup_assertions #(
  parameter MINUTE_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       faultValid,
  input wire logic [7:0] faultCode,
  input wire logic       faultResetIn,
  input wire logic       stopResetKey,
  input wire logic       coastStop,
  input wire logic       runningIndicator,
  input wire logic [7:0] displayCode,
  input wire logic       displayFlash
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Anything that may clear the fault latch
  wire logic anyReq = faultResetIn | stopResetKey | wb_cyc_i;
  // Reset request followed by a quiet cycle
  sequence clearSeq;
    faultResetIn && !faultValid ##1 !faultValid;
  endsequence
  // Fault arriving with nothing latched
  sequence firstSeq;
    faultValid && !coastStop;
  endsequence
  ////////////////////////////////////////
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a one-cycle answer");
  alarm_nostop_a: assert property (!faultValid && !coastStop |=> !coastStop)
    else $error("coast without a fault");
  run_keep_a: assert property (runningIndicator && !faultValid && !stopResetKey |=> runningIndicator)
    else $error("drive stopped without cause");
  fault_coast_a: assert property (faultValid |=> coastStop && !runningIndicator)
    else $error("fault did not stop drive");
  flash_match_a: assert property (displayFlash == (displayCode != 8'h00))
    else $error("flash disagrees with code");
  fault_show_a: assert property (firstSeq |-> ##2 displayCode == $past(faultCode, 2))
    else $error("first fault not displayed");
  fault_hold_a: assert property (
    $past(coastStop, 2) && $past(coastStop) && coastStop &&
    !$past(anyReq, 2) && !$past(anyReq, 3) |-> $stable(displayCode))
    else $error("latched fault display changed");
  latch_keep_a: assert property (coastStop && !anyReq && !$past(anyReq) |=> coastStop)
    else $error("fault latch dropped unasked");
  latch_clear_a: assert property (clearSeq |=> !coastStop)
    else $error("fault reset not honoured");
endmodule
bind afel_supervisor afel_sup_assertions #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .faultValid(faultValid), .faultCode(faultCode), .faultResetIn(faultResetIn),
  .stopResetKey(stopResetKey), .coastStop(coastStop), .runningIndicator(runningIndicator),
  .displayCode(displayCode), .displayFlash(displayFlash)
);
`default_nettype wire

// ==== tb/afel_operator_model.sv ====
// Keypad stop/reset key and fault reset source model.
// Assumes one-cycle request pulses from the bench on mclk.
`timescale 1ns/1ps
`default_nettype none
module afel_operator_model (
  input  wire logic mclk,
  input  wire logic slow,
  input  wire logic keyReq,
  input  wire logic resetReq,
  output var  logic stopResetKey,
  output var  logic faultResetIn
);
  logic keyDly;
  logic rstDly;
  // One-cycle press, either prompt or one cycle late
  always @(posedge mclk) begin
    keyDly <= keyReq;
    rstDly <= resetReq;
    stopResetKey <= slow ? keyDly : keyReq;
    faultResetIn <= slow ? rstDly : resetReq;
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the alarm, fault and log supervisor.
// Assumes afel_supervisor, its checker and the operator model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rst, nvClear, cyc, stb, we, ack, lineLow, faultValid, startCmd;
  logic        idDone, tuneDone, keyReq, resetReq, slow, stopResetKey, faultResetIn;
  logic        runningIndicator, coastStop, displayFlash, idRunning, tuneRunning, ll;
  logic [3:0]  sel, m;
  logic [5:0]  adr;
  logic [7:0]  faultCode, displayCode, c;
  logic [9:0]  dcBusVolts, lv, v;
  logic [15:0] loopMicroAmps, ua;
  logic [31:0] dat, datO, q;
  logic [7:0]  codes[$];
  int          errors, tests_run;
  integer      seed = 32'hf9bc2091;
  afel_supervisor #(.MINUTE_CYCLES(20)) u_dut (
    .mclk(mclk), .rst(rst), .nvClear(nvClear), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .dcBusVolts(dcBusVolts), .loopMicroAmps(loopMicroAmps),
    .lineLow(lineLow), .faultValid(faultValid), .faultCode(faultCode),
    .startCmd(startCmd), .stopResetKey(stopResetKey), .faultResetIn(faultResetIn),
    .idDone(idDone), .tuneDone(tuneDone), .runningIndicator(runningIndicator),
    .coastStop(coastStop), .displayCode(displayCode), .displayFlash(displayFlash),
    .idRunning(idRunning), .tuneRunning(tuneRunning)
  );
  afel_operator_model u_op (
    .mclk(mclk), .slow(slow), .keyReq(keyReq), .resetReq(resetReq),
    .stopResetKey(stopResetKey), .faultResetIn(faultResetIn)
  );
  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    complete_run();
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Classic single bus cycle; read data lands in q
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= d;
    // Only the watchdog ends a wait that never sees ack
    do @(posedge mclk);
    while (ack !== 1'b1);
    q = datO;
    {cyc, stb} <= 2'b00;
  endtask
  // Pulse start, key or fault reset, then let it settle
  task go(input int w);
    @(posedge mclk);
    case (w)
      0: startCmd <= 1'b1;
      1: keyReq <= 1'b1;
      default: resetReq <= 1'b1;
    endcase
    @(posedge mclk);
    {startCmd, keyReq, resetReq} <= 3'h0;
    repeat (5) @(posedge mclk);
  endtask
  // Expected alarm code with no procedure enabled
  function automatic logic [7:0] expAlarm(input logic [9:0] v, lv, input logic [15:0] ua,
                                          input logic [3:0] m, input logic ll);
    if (v > ((lv > 10'h19f) ? 10'h2e5 : 10'h29d)) return 8'h02;
    if (m >= 4'h8 && m <= 4'hb && ua < 16'h07d0) return 8'h01;
    if (ll) return 8'h05;
    return 8'h00;
  endfunction
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {cyc, stb, we, lineLow, faultValid, startCmd, idDone, tuneDone, keyReq, resetReq} = '0;
    {adr, dat, dcBusVolts, faultCode, slow} = '0;
    sel = 4'hf;
    loopMicroAmps = 16'hffff;
    {rst, nvClear} = 2'b11;
    repeat (10) @(posedge mclk);
    {rst, nvClear} <= 2'b00;
    wb(1'b0, 6'h04, 0); chk(q, 32'h1cc);
    wb(1'b0, 6'h20, 0); chk(q, 32'h0);
    wb(1'b0, 6'h18, 0); chk(q, 32'h0);
    go(0); chk(32'(runningIndicator), 1);
    for (int i = 0; i < 16; i++) begin
      lv = i[0] ? 10'h1a0 : 10'h19f;
      v = (i[0] ? 10'h2e4 : 10'h29c) + 10'({$random(seed)} % 3);
      if (i > 9) v = 10'($random(seed));
      m = 4'($random(seed));
      if (i[1]) m[3:2] = 2'b10;
      ua = 16'h07ce + 16'({$random(seed)} % 4);
      ll = 1'($random(seed));
      wb(1'b1, 6'h04, {22'h0, lv});
      wb(1'b1, 6'h08, {28'h0, m});
      dcBusVolts <= v;
      loopMicroAmps <= ua;
      lineLow <= ll;
      repeat (3) @(posedge mclk);
      chk(32'(displayCode), 32'(expAlarm(v, lv, ua, m, ll)));
    end
    dcBusVolts <= 10'h0;
    lineLow <= 1'b0;
    loopMicroAmps <= 16'hffff;
    repeat (3) @(posedge mclk);
    chk(32'(displayCode), 0);
    chk({coastStop, runningIndicator}, 32'h1);
    go(1);
    $display("alarm test done");
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      wb(1'b1, 6'h00, 32'(1 << p));
      repeat (3) @(posedge mclk);
      chk(32'(displayCode), p ? 7 : 4);
      go(0); chk(32'(displayCode), p ? 6 : 3);
      chk(32'(p ? tuneRunning : idRunning), 1);
      go(1); chk({displayCode, p ? tuneRunning : idRunning}, 0);
      wb(1'b1, 6'h00, 32'(1 << p));
      wb(1'b1, 6'h00, 0);
      repeat (3) @(posedge mclk);
      chk(32'(displayCode), 0);
    end
    // Procedures that finish by themselves drop their alarm
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, 6'h00, 32'(1 << p));
      go(0);
      {tuneDone, idDone} <= 2'(1 << p);
      @(posedge mclk);
      {tuneDone, idDone} <= 2'b00;
      repeat (3) @(posedge mclk);
      chk({displayCode, idRunning, tuneRunning}, 0);
    end
    $display("procedure test done");
    go(0);
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      c = 8'($random(seed));
      c[0] = 1'b1;
      codes.push_back(c);
      faultValid <= 1'b1;
      faultCode <= c;
    end
    @(posedge mclk);
    faultValid <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({coastStop, runningIndicator}, 32'h2);
    chk(32'(displayCode), 32'(codes[0]));
    wb(1'b0, 6'h0c, 0); chk(32'(q[7:0]), 32'(codes[0]));
    wb(1'b0, 6'h18, 0); chk(q, 10);
    for (int s = 0; s < 10; s++) begin
      wb(1'b1, 6'h10, s);
      wb(1'b0, 6'h14, 0);
      chk(32'(q[26:19]), 32'(codes[11 - s]));
      chk(32'(q[30:27]), 9 - s);
    end
    wb(1'b1, 6'h10, 10); wb(1'b0, 6'h10, 0); chk(q, 9);
    go(2); chk({coastStop, displayCode}, 0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, 6'h18, 0); chk(q, 10);
    $display("fault log test done");
    wb(1'b1, 6'h00, 32'h4);
    repeat (64) @(posedge mclk);
    wb(1'b0, 6'h1c, 0); chk(q, 3);
    @(posedge mclk);
    faultValid <= 1'b1;
    faultCode <= 8'h5a;
    @(posedge mclk);
    faultValid <= 1'b0;
    wb(1'b1, 6'h10, 0);
    wb(1'b0, 6'h14, 0); chk(q[26:0], {8'h5a, 19'h3});
    wb(1'b1, 6'h00, 32'h8);
    repeat (3) @(posedge mclk);
    chk(32'(coastStop), 0);
    // Sixty-three minutes after a clock reset: one hour, three minutes
    wb(1'b1, 6'h00, 32'h4);
    repeat (1264) @(posedge mclk);
    wb(1'b0, 6'h1c, 0); chk(q, 32'h43);
    $display("clock test done");
    complete_run();
  end
endmodule
`default_nettype wire
